// ---- sar_consts.vh ----
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SAR_RES_W 12
`define SAR_LEAD_ZEROS 4
`define SAR_FRAME_BITS 16
`define SAR_CNT_W 5
`define SAR_TRACK_EDGE 5'h0D
`define SAR_CNT_ZERO 5'h00
`define SAR_CNT_ONE 5'h01
`define SAR_RES_ZERO 12'h000
`define SAR_BIT_HI 1'b1
`define SAR_BIT_LO 1'b0
// ----------------------------------------
// Conversion and slot limits
// ----------------------------------------
`define SAR_CNT_MAX 5'h1F
`define SAR_LAST_TRIAL 5'h0C
`define SAR_TRACK_PREV 5'h0C
`define SAR_TRIAL_MSB 12'h800
`define SAR_ZERO_NIB 4'h0
`define SAR_SLOT_END 5'h10
`endif

// ---- sar_sync2.v ----
`timescale 1ns/1ns
module sar_sync2 #(
  // Idle level of the pin, so reset shows no false edge
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Async level in, synced level out
  input wire d,
  output reg q
);
  reg meta_q;
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sar_sync2

// ---- sar_readout.v ----
`timescale 1ns/1ns
`include "sar_consts.vh"
module sar_readout (
  // System
  input wire clk,
  input wire srst,
  // Serial link pins
  input wire cs_n,
  input wire sclk,
  output reg serial_result_out,
  output reg serial_result_oe,
  // Comparator from analog core
  input wire cmp_in,
  // Track/hold and result status
  output reg track_q,
  output reg [11:0] result_q,
  output reg result_valid_q
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire cs_n_s;
  wire sclk_s;
  wire cmp_s;
  // Chip select idles high; a low reset value would fake a frame start
  sar_sync2 #(.RST_VAL(`SAR_BIT_HI)) u_cs (.clk(clk), .srst(srst), .d(cs_n), .q(cs_n_s));
  sar_sync2 u_ck (.clk(clk), .srst(srst), .d(sclk), .q(sclk_s));
  sar_sync2 u_cm (.clk(clk), .srst(srst), .d(cmp_in), .q(cmp_s));

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  reg cs_n_q;
  reg sclk_q;
  wire cs_fall = cs_n_q & ~cs_n_s;
  wire sclk_rise = ~sclk_q & sclk_s;
  wire sclk_fall = sclk_q & ~sclk_s;
  always @(posedge clk) begin
    if (srst) begin
      cs_n_q <= `SAR_BIT_HI;
      sclk_q <= `SAR_BIT_LO;
    end else begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_FRAME = 1'b1;
  reg state_q;
  reg state_d;
  // Host may cut a frame short at any point
  wire frame_start = (state_q == ST_IDLE) & cs_fall;
  wire frame_end = (state_q == ST_FRAME) & cs_n_s;
  wire in_frame = (state_q == ST_FRAME) & ~cs_n_s;

  // Chip select alone opens and closes a frame
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_n_s) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Serial clock edge counters
  // ----------------------------------------
  reg [4:0] rise_cnt_q;
  reg [4:0] fall_cnt_q;
  // Edges only count inside a frame
  wire rise_hit = in_frame & sclk_rise;
  wire fall_hit = in_frame & sclk_fall;

  // Saturate so surplus clocks never wrap back into the result slots
  always @(posedge clk) begin
    if (srst) begin
      rise_cnt_q <= `SAR_CNT_ZERO;
    end else if (frame_start) begin
      rise_cnt_q <= `SAR_CNT_ZERO;
    end else if (rise_hit && rise_cnt_q != `SAR_CNT_MAX) begin
      rise_cnt_q <= rise_cnt_q + `SAR_CNT_ONE;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      fall_cnt_q <= `SAR_CNT_ZERO;
    end else if (frame_start) begin
      fall_cnt_q <= `SAR_CNT_ZERO;
    end else if (fall_hit && fall_cnt_q != `SAR_CNT_MAX) begin
      fall_cnt_q <= fall_cnt_q + `SAR_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Successive approximation
  // ----------------------------------------
  reg [11:0] sar_q;
  // Trial bit as one-hot, moving down one place per rising edge
  reg [11:0] trial_q;
  // Rises 1..12 settle one bit each, MSB first
  wire sar_step = rise_hit && (rise_cnt_q < `SAR_LAST_TRIAL);

  always @(posedge clk) begin
    if (srst) begin
      sar_q <= `SAR_RES_ZERO;
      trial_q <= `SAR_RES_ZERO;
    end else if (frame_start) begin
      sar_q <= `SAR_RES_ZERO;
      trial_q <= `SAR_TRIAL_MSB;
    end else if (sar_step) begin
      // Keep trial bit while input is above the DAC level
      if (cmp_s) begin
        sar_q <= sar_q | trial_q;
      end
      trial_q <= {`SAR_BIT_LO, trial_q[11:1]};
    end
  end

  // ----------------------------------------
  // Track/hold and result
  // ----------------------------------------
  // Thirteenth rise: all twelve bits are settled by now
  wire track_hit = rise_hit && (rise_cnt_q == `SAR_TRACK_PREV);

  // Sample is held from the chip-select edge until tracking resumes
  always @(posedge clk) begin
    if (srst) begin
      track_q <= `SAR_BIT_HI;
    end else if (frame_start) begin
      track_q <= `SAR_BIT_LO;
    end else if (frame_end) begin
      track_q <= `SAR_BIT_HI;
    end else if (track_hit) begin
      track_q <= `SAR_BIT_HI;
    end
  end

  // A cut frame never loads a partial result
  always @(posedge clk) begin
    if (srst) begin
      result_q <= `SAR_RES_ZERO;
      result_valid_q <= `SAR_BIT_LO;
    end else begin
      result_valid_q <= `SAR_BIT_LO;
      if (track_hit) begin
        result_q <= sar_q;
        result_valid_q <= `SAR_BIT_HI;
      end
    end
  end

  // ----------------------------------------
  // Output slot map
  // ----------------------------------------
  // Slot 0 goes out first; leading zeros, then result MSB first
  wire [15:0] frame_word = {`SAR_ZERO_NIB, sar_q};
  wire [15:0] slot_vec;
  genvar g;
  generate
    for (g = 0; g < `SAR_FRAME_BITS; g = g + 1) begin : g_slot
      assign slot_vec[g] = frame_word[`SAR_FRAME_BITS - 1 - g];
    end
  endgenerate

  // Each result bit is decided three rises before its slot is shown
  wire [4:0] next_slot = fall_cnt_q + `SAR_CNT_ONE;
  // Falls from the sixteenth on give zeros
  wire next_bit = (next_slot < `SAR_SLOT_END) ? slot_vec[next_slot[3:0]] : `SAR_BIT_LO;

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Slot 0 is driven at chip select, the rest one per falling edge
  always @(posedge clk) begin
    if (srst) begin
      serial_result_out <= `SAR_BIT_LO;
      serial_result_oe <= `SAR_BIT_LO;
    end else if (frame_start) begin
      serial_result_oe <= `SAR_BIT_HI;
      serial_result_out <= `SAR_BIT_LO;
    end else if (frame_end) begin
      serial_result_oe <= `SAR_BIT_LO;
      serial_result_out <= `SAR_BIT_LO;
    end else if (fall_hit) begin
      serial_result_out <= next_bit;
    end
  end
endmodule // sar_readout

// ---- sar_readout_chk.sv ----
`timescale 1ns/1ns
module sar_readout_chk (
  // Watched ports
  input wire clk,
  input wire srst,
  input wire cs_n,
  input wire sclk,
  input wire serial_result_out,
  input wire serial_result_oe,
  input wire track_q,
  input wire result_valid_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_oe; $fell(cs_n) |-> ##[1:6] (serial_result_oe && !track_q); endproperty
  a_oe: assert property (p_oe) else $error("no frame start");
  property p_hold; $rose(sclk) |-> ##2 $stable(serial_result_out) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_trk; $rose(result_valid_q) |-> ##[0:1] track_q; endproperty
  a_trk: assert property (p_trk) else $error("no track");
  property p_oe_off; $rose(cs_n) |-> ##[1:6] !serial_result_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output not released");
  property p_lead; $rose(serial_result_oe) |-> (!serial_result_out && !track_q); endproperty
  a_lead: assert property (p_lead) else $error("bad frame opening");
  property p_pulse; result_valid_q |=> !result_valid_q; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
endmodule // sar_readout_chk
bind sar_readout sar_readout_chk chk (.*);

// ---- sar_host_model.sv ----
`timescale 1ns/1ns
module sar_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic cs_n = 1'b1,
  output logic sclk = 1'b0,
  output logic cmp_in = 1'b0,
  input wire logic serial_result_out
);
  // Read late: synced pins lag data by about three clocks
  task automatic frame(input logic [11:0] code, input int nclk, output logic [15:0] word);
    word = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    cmp_in <= code[11];
    for (int i = 0; i < nclk; i++) begin
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      word[15 - i] = serial_result_out;
      sclk <= 1'b0;
      cmp_in <= (i < 11) ? code[10 - i] : 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
endmodule // sar_host_model

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
  logic clk, srst, cs_n, sclk, cmp_in, serial_result_out, serial_result_oe;
  logic track_q, result_valid_q;
  logic [11:0] result_q, code;
  logic [15:0] word;
  int num_errors = 0, n_compared = 0, n_vld = 0, n_full = 0, nclk = 16, seed = 32'h3f1f;
  sar_readout uut (
    .clk(clk),
    .srst(srst),
    .cs_n(cs_n),
    .sclk(sclk),
    .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe),
    .cmp_in(cmp_in),
    .track_q(track_q),
    .result_q(result_q),
    .result_valid_q(result_valid_q)
  );
  sar_host_model host (
    .clk(clk),
    .cs_n(cs_n),
    .sclk(sclk),
    .cmp_in(cmp_in),
    .serial_result_out(serial_result_out)
  );
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) n_vld <= n_vld + (result_valid_q === 1'b1);
  function automatic logic [15:0] ew(input logic [11:0] c);
    return {4'h0, c};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("%0d checks %0d errors", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      code = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : (i == 2) ? 12'hA5A : 12'($random(seed));
      nclk = (i == 5) ? 8 : 16;
      host.frame(code, nclk, word);
      if (nclk == 16) begin
        n_full++;
        check(word, ew(code));
        check(ew(result_q), ew(code));
      end
      check(16'(n_vld), 16'(n_full));
      check({15'h0000, track_q & ~serial_result_oe}, 16'h0001);
      $display("frame %0d done", i);
    end
    stop_test();
  end
endmodule // tb
